// ---- lcl_pkg.sv ----
// constants shared by both ends of the configuration loader link
// assumes a single 20 MHz sys_clk domain on each end
package lcl_pkg;
   // register byte offsets inside the capability block
   localparam logic [11:0] OFS_ID_STATUS = 12'h21c;
   localparam logic [11:0] OFS_MODE = 12'h220;
   localparam logic [11:0] OFS_DATA = 12'h228;
   localparam logic [11:0] OFS_PROG = 12'h22c;
   // status field positions (upper half of the id word)
   localparam int ST_CORE_READY = 9;
   localparam int ST_CLK_IN_USE = 8;
   localparam int ST_DONE = 7;
   localparam int ST_HALF_RATE = 6;
   localparam int ST_USER_MODE = 5;
   localparam int ST_LOAD_EN = 4;
   localparam int ST_ERROR = 3;
   localparam int ST_READY = 2;
   // mode control field positions
   localparam int MC_NCLK_LO = 8;
   localparam int MC_NCLK_HI = 15;
   localparam int MC_FULL = 2;
   localparam int MC_CLKSEL = 1;
   localparam int MC_MODE = 0;
   localparam logic [5:0] NCLK_ZERO_MEANS = 6'h00;
   localparam logic [6:0] NCLK_FULL = 7'h40;
   // uncorrectable internal error bit for load errors
   localparam int UE_LOAD_ERR = 5;
   localparam logic [11:0] OFS_UE_STATUS = 12'h234;
   // reset value of writable registers
   localparam logic [31:0] REG_RESET = 32'h0000_0000;
   localparam logic [15:0] BOARD_ID_DEFAULT = 16'h0000;
   // host-side apb map of the controller's own registers
   localparam logic [7:0] HA_CMD_ADDR = 8'h00;
   localparam logic [7:0] HA_WDATA = 8'h04;
   localparam logic [7:0] HA_RDATA = 8'h08;
   localparam logic [7:0] HA_STATUS = 8'h0c;
   localparam logic [7:0] HA_MEMWR = 8'h10;
endpackage : lcl_pkg

// ---- lcl_if.sv ----
// request link between the programming host and the loader registers
// assumes both ends run on the same sys_clk
`timescale 1ns/100ps
`default_nettype none
interface lcl_if (input wire logic sys_clk);
   logic req;      // request valid, held until ack
   logic we;       // write when high
   logic memwr;    // memory-space write instead of config write
   logic [11:0] addr;
   logic [3:0] be;
   logic [31:0] wdata;
   logic ack;      // one-cycle answer
   logic [31:0] rdata;
   modport dev (input req, we, memwr, addr, be, wdata, output ack, rdata);
   modport host (output req, we, memwr, addr, be, wdata, input ack, rdata);
endinterface : lcl_if
`default_nettype wire

// ---- lcl_dev.sv ----
// loader register block inside the link core
// assumes control-block inputs are asynchronous and fabric-side levels
`timescale 1ns/100ps
`default_nettype none
// Function
// RULE1: board id reads back fixed parameter
// RULE2: status 9 shows fabric core ready
// RULE3: status 8 shows fabric clock in use
// RULE4: status 7 shows load done
// RULE5: status 6 shows half rate select
// RULE6: status 5 shows fabric user mode
// RULE7: status 4 shows link load enabled
// RULE8: status 3 mirrors load error
// RULE9: status 2 mirrors load ready
// RULE10: clocks per write, zero means 64
// RULE11: top two count bits stored, unused
// RULE12: mode bit 2 requests full reload
// RULE13: mode bit 1 selects core clock
// RULE14: software waits idle around clock switch
// RULE15: mode bit 0 enters load mode
// RULE16: load mode refused without load enable
// RULE17: data write drives word then clocks
// RULE18: software enables all data byte lanes
// RULE19: data via config or memory write
// RULE20: data register 32 bits, resets zero
// RULE21: programming control start and request bits
// RULE22: rising load error sets sticky bit; code sets it only in load mode
// RULE23: reserved bits read zero
// RULE24: clock burst finishes before next data
module lcl_dev #(
   parameter logic [15:0] BOARD_ID = lcl_pkg::BOARD_ID_DEFAULT
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // link side
   lcl_if.dev bus,
   // from configuration control block and fabric
   input wire logic fabric_core_ready,
   input wire logic fabric_clock_in_use,
   input wire logic load_done,
   input wire logic half_rate_select,
   input wire logic fabric_user_mode,
   input wire logic link_load_enabled,
   input wire logic load_error,
   input wire logic load_ready,
   // to configuration control block
   output logic [31:0] load_data,
   output logic load_clk_en,
   output logic link_load_mode,
   output logic full_reload_request,
   output logic core_clock_source,
   output logic transfer_start,
   output logic load_request
);
   // two-flop synchronisers for the outside levels
   logic [7:0] in_raw, s1_reg, s2_reg;
   assign in_raw = {fabric_core_ready, fabric_clock_in_use, load_done,
                    half_rate_select, fabric_user_mode, link_load_enabled,
                    load_error, load_ready};
   always_ff @(posedge sys_clk)
   begin
      s1_reg <= srst ? 8'h00 : in_raw;
      s2_reg <= srst ? 8'h00 : s1_reg;
   end
   logic core_rdy_s, clk_use_s, done_s, half_s, user_s, en_s, err_s, rdy_s;
   assign {core_rdy_s, clk_use_s, done_s, half_s, user_s, en_s, err_s,
           rdy_s} = s2_reg;

   // status word, reserved bits tied low
   logic [15:0] status;
   always_comb
   begin
      status = 16'h0000; // see RULE23
      status[lcl_pkg::ST_CORE_READY] = core_rdy_s; // see RULE2
      status[lcl_pkg::ST_CLK_IN_USE] = clk_use_s; // see RULE3
      status[lcl_pkg::ST_DONE] = done_s; // see RULE4
      status[lcl_pkg::ST_HALF_RATE] = half_s; // see RULE5
      status[lcl_pkg::ST_USER_MODE] = user_s; // see RULE6
      status[lcl_pkg::ST_LOAD_EN] = en_s; // see RULE7
      status[lcl_pkg::ST_ERROR] = err_s; // see RULE8
      status[lcl_pkg::ST_READY] = rdy_s; // see RULE9
   end

   // registers
   logic [7:0] nclk_reg;
   logic mode_reg, clksel_reg, full_reg;
   logic [31:0] data_reg;
   logic [1:0] prog_reg;
   logic ue_reg, err_d_reg, rd_ok_reg;
   logic [6:0] burst_reg;

   // decode; memory writes reach data only in load mode
   logic wr, hit_mode, hit_data, hit_prog, hit_ue, busy, data_wr;
   assign wr = bus.req & bus.we;
   assign hit_mode = wr & ~bus.memwr & (bus.addr == lcl_pkg::OFS_MODE);
   assign hit_prog = wr & ~bus.memwr & (bus.addr == lcl_pkg::OFS_PROG);
   assign hit_ue = wr & ~bus.memwr & (bus.addr == lcl_pkg::OFS_UE_STATUS);
   assign hit_data = wr & (bus.memwr ? mode_reg
                    : (bus.addr == lcl_pkg::OFS_DATA)); // see RULE19
   assign busy = (burst_reg != 7'h00);
   // a data write waits for the burst; reads answer a cycle late
   assign data_wr = hit_data & ~busy; // see RULE24
   assign bus.ack = bus.req & (bus.we ? ~(hit_data & busy) : rd_ok_reg);

   // burst length from the low six count bits
   logic [6:0] nclks;
   assign nclks = (nclk_reg[5:0] == lcl_pkg::NCLK_ZERO_MEANS)
                  ? lcl_pkg::NCLK_FULL : {1'b0, nclk_reg[5:0]}; // see RULE10
   logic err_rise;
   assign err_rise = err_s & ~err_d_reg & mode_reg;

   // mode control, byte-lane masked
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         nclk_reg <= 8'h00;
         mode_reg <= 1'b0;
         clksel_reg <= 1'b0;
         full_reg <= 1'b0;
      end
      else if (hit_mode)
      begin
         if (bus.be[1])
            nclk_reg <= bus.wdata[lcl_pkg::MC_NCLK_HI:
                                  lcl_pkg::MC_NCLK_LO]; // see RULE11
         if (bus.be[0])
         begin
            mode_reg <= bus.wdata[lcl_pkg::MC_MODE] & en_s; // see RULE15 RULE16
            clksel_reg <= bus.wdata[lcl_pkg::MC_CLKSEL]; // see RULE13
            full_reg <= bus.wdata[lcl_pkg::MC_FULL]; // see RULE12
         end
      end
      else if (!en_s)
         mode_reg <= 1'b0; // see RULE16
   end

   // data word, clock burst, programming control
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         data_reg <= lcl_pkg::REG_RESET; // see RULE20
         burst_reg <= 7'h00;
         prog_reg <= 2'b00;
      end
      else
      begin
         if (data_wr)
         begin
            data_reg <= bus.wdata; // see RULE17
            burst_reg <= nclks;
         end
         else if (busy)
            burst_reg <= burst_reg - 7'h01;
         if (hit_prog && bus.be[0])
            prog_reg <= bus.wdata[1:0]; // see RULE21
      end
   end

   // sticky load error, write one to clear, set wins
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         ue_reg <= 1'b0;
         err_d_reg <= 1'b0;
      end
      else
      begin
         err_d_reg <= err_s;
         if (err_rise)
            ue_reg <= 1'b1; // see RULE22
         else if (hit_ue && bus.be[0] && bus.wdata[lcl_pkg::UE_LOAD_ERR])
            ue_reg <= 1'b0;
      end
   end

   // read mux
   logic [31:0] rd_next, rd_reg;
   always_comb
   begin
      rd_next = 32'h0000_0000;
      case (bus.addr)
         lcl_pkg::OFS_ID_STATUS: rd_next = {status, BOARD_ID}; // see RULE1
         lcl_pkg::OFS_MODE: rd_next = {16'h0000, nclk_reg, 5'h00,
                                       full_reg, clksel_reg, mode_reg};
         lcl_pkg::OFS_DATA: rd_next = data_reg;
         lcl_pkg::OFS_PROG: rd_next = {30'h0, prog_reg};
         lcl_pkg::OFS_UE_STATUS: rd_next = {26'h0, ue_reg, 5'h00};
         default: rd_next = 32'h0000_0000;
      endcase
   end
   // read data from a flop; rd_ok_reg marks the one answer cycle
   always_ff @(posedge sys_clk)
   begin
      rd_reg <= srst ? 32'h0000_0000 : rd_next;
      rd_ok_reg <= ~srst & bus.req & ~bus.we & ~rd_ok_reg;
   end
   assign bus.rdata = rd_reg;

   // outputs from flops
   assign load_data = data_reg;
   assign load_clk_en = busy; // one enable per load clock
   assign link_load_mode = mode_reg; // see RULE15
   assign full_reload_request = full_reg;
   assign core_clock_source = clksel_reg & user_s & core_rdy_s; // see RULE13
   assign transfer_start = prog_reg[1];
   assign load_request = prog_reg[0];
endmodule : lcl_dev
`default_nettype wire

// ---- lcl_host.sv ----
// programming host end: apb slave for software, drives the link
// assumes device answers with a one-cycle ack
`timescale 1ns/100ps
`default_nettype none
module lcl_host (
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // software apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // link
   lcl_if.host bus
);
   // command: bit 12 go, bit 13 write, bits 11:0 address
   logic [11:0] addr_reg;
   logic we_reg, memwr_reg, req_reg;
   logic [31:0] wd_reg, rd_reg;
   logic acc, wr_go, hit_any;
   assign acc = psel & penable;
   assign hit_any = (paddr == lcl_pkg::HA_CMD_ADDR) |
                    (paddr == lcl_pkg::HA_WDATA) |
                    (paddr == lcl_pkg::HA_RDATA) |
                    (paddr == lcl_pkg::HA_STATUS) |
                    (paddr == lcl_pkg::HA_MEMWR);
   assign wr_go = acc & pwrite & (paddr == lcl_pkg::HA_CMD_ADDR) & pwdata[12];
   // new commands stall while one is outstanding
   assign pready = ~(req_reg & pwrite & (paddr == lcl_pkg::HA_CMD_ADDR));
   assign pslverr = acc & ~hit_any;
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         addr_reg <= 12'h000;
         we_reg <= 1'b0;
         memwr_reg <= 1'b0;
         req_reg <= 1'b0;
         wd_reg <= 32'h0000_0000;
         rd_reg <= 32'h0000_0000;
      end
      else
      begin
         if (acc && pwrite && paddr == lcl_pkg::HA_WDATA)
            wd_reg <= pwdata;
         if (acc && pwrite && paddr == lcl_pkg::HA_MEMWR)
            memwr_reg <= pwdata[0];
         if (wr_go && !req_reg)
         begin
            addr_reg <= pwdata[11:0];
            we_reg <= pwdata[13];
            req_reg <= 1'b1;
         end
         else if (bus.ack)
         begin
            req_reg <= 1'b0;
            rd_reg <= bus.rdata;
         end
      end
   end
   // all byte lanes always enabled
   assign bus.req = req_reg;
   assign bus.we = we_reg;
   assign bus.memwr = memwr_reg;
   assign bus.addr = addr_reg;
   assign bus.be = 4'hf; // see RULE18
   assign bus.wdata = wd_reg;
   // apb read mux
   always_comb
   begin
      case (paddr)
         lcl_pkg::HA_RDATA: prdata = rd_reg;
         lcl_pkg::HA_STATUS: prdata = {31'h0, req_reg};
         lcl_pkg::HA_WDATA: prdata = wd_reg;
         lcl_pkg::HA_MEMWR: prdata = {31'h0, memwr_reg};
         default: prdata = 32'h0000_0000;
      endcase
   end
endmodule : lcl_host
`default_nettype wire

// ---- lcl_sva.sv ----
// checker on the request link and the load output of the loader
// assumes one sys_clk domain and srst synchronous, active high
`timescale 1ns/100ps
`default_nettype none
module lcl_sva (
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // link signals
   input wire logic req,
   input wire logic we,
   input wire logic memwr,
   input wire logic [11:0] addr,
   input wire logic [3:0] be,
   input wire logic [31:0] wdata,
   input wire logic ack,
   // load side
   input wire logic [31:0] load_data,
   input wire logic load_clk_en,
   input wire logic link_load_mode,
   input wire logic link_load_enabled
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   logic [7:0] run_reg;
   logic [7:0] run_next;
   // data writes: config to the data offset, memory ones in load mode
   wire data_wr = req && we
      && (memwr ? link_load_mode : (addr == lcl_pkg::OFS_DATA));
   // burst length; a stuck enable trips the bound long before wrapping
   assign run_next = load_clk_en ? run_reg + 8'h01 : 8'h00;
   always_ff @(posedge sys_clk)
   begin
      run_reg <= srst ? 8'h00 : run_next;
   end
   a_ack_req: assert property (ack |-> req)
      else $error("ack without request");
   a_req_held: assert property (req && !ack |=> req && $stable(addr)
      && $stable(wdata) && $stable(we)) else $error("request changed");
   a_full_lanes: assert property (req && we |-> be == 4'hf)
      else $error("byte lanes missing");
   a_ack_pulse: assert property (ack |=> !ack)
      else $error("ack longer than one cycle");
   a_data_word: assert property (data_wr && ack |=> load_clk_en
      && load_data == $past(wdata)) else $error("data word not driven");
   a_burst_block: assert property (data_wr && load_clk_en
      |-> !ack) else $error("data taken during burst");
   a_data_hold: assert property (load_clk_en
      && $past(load_clk_en) |-> $stable(load_data))
      else $error("data moved in burst");
   a_burst_limit: assert property (run_reg <= 8'h40)
      else $error("burst longer than 64");
   a_mode_refused: assert property (!link_load_enabled [*5]
      |-> !link_load_mode) else $error("load mode without enable");
   c_data: cover property (data_wr && ack);
   c_burst: cover property ($fell(load_clk_en));
   c_mode: cover property (link_load_mode);
   c_memwr: cover property (data_wr && memwr && ack);
endmodule : lcl_sva
`default_nettype wire

// ---- lcl_bench.sv ----
// self-checking bench: apb host end joined to the loader registers
// assumes nothing outside; makes clock, reset and status levels
`timescale 1ns/100ps
`default_nettype none
module lcl_bench;
   localparam logic [15:0] BID = 16'h5a3c; // arbitrary board id
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   localparam int IDLE_CYC = 200; // 10 us of sys_clk
   logic [31:0] prdata, load_data, q, d, n;
   logic [31:0] run = 32'h0;
   logic pready, load_clk_en, link_load_mode, full_reload_request;
   logic core_clock_source, transfer_start, load_request;
   logic [7:0] st = 8'h00; // status levels 9 down to 2
   logic [7:0] cnt [5] = '{8'h01, 8'h00, 8'h3f, 8'h02, 8'hc5};
   logic [31:0] exp_d[$];
   logic [31:0] exp_n[$];
   int seed = 55;
   int err_total = 0;
   int total_checks = 0;
   always #25 sys_clk = ~sys_clk;
   lcl_if lcl_if_i (.sys_clk(sys_clk));
   lcl_host lcl_host_i (.sys_clk(sys_clk), .srst(srst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(), .bus(lcl_if_i.host));
   lcl_dev #(.BOARD_ID(BID)) lcl_dev_i (.sys_clk(sys_clk), .srst(srst),
      .bus(lcl_if_i.dev), .fabric_core_ready(st[7]),
      .fabric_clock_in_use(st[6]), .load_done(st[5]),
      .half_rate_select(st[4]), .fabric_user_mode(st[3]),
      .link_load_enabled(st[2]), .load_error(st[1]), .load_ready(st[0]),
      .load_data(load_data), .load_clk_en(load_clk_en),
      .link_load_mode(link_load_mode),
      .full_reload_request(full_reload_request),
      .core_clock_source(core_clock_source),
      .transfer_start(transfer_start), .load_request(load_request));
   lcl_sva lcl_sva_i (.sys_clk(sys_clk), .srst(srst), .req(lcl_if_i.req),
      .we(lcl_if_i.we), .memwr(lcl_if_i.memwr), .addr(lcl_if_i.addr),
      .be(lcl_if_i.be), .wdata(lcl_if_i.wdata), .ack(lcl_if_i.ack),
      .load_data(load_data),
      .load_clk_en(load_clk_en), .link_load_mode(link_load_mode),
      .link_load_enabled(st[2]));
   task automatic chk(input string nm, input logic [31:0] s, e);
      total_checks++;
      if (s !== e)
      begin
         err_total++;
         $display("MISMATCH %0s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_of_test
   // one apb transfer, held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd_q);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd_q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // device access: data, command, poll busy, fetch the answer
   task automatic dev(input logic w, input logic [11:0] a,
      input logic [31:0] wd, output logic [31:0] rd_q);
      apb(1'b1, lcl_pkg::HA_WDATA, wd, rd_q);
      apb(1'b1, lcl_pkg::HA_CMD_ADDR, {18'h0, w, 1'b1, a}, rd_q);
      rd_q = 32'h1;
      while (rd_q[0] !== 1'b0) apb(1'b0, lcl_pkg::HA_STATUS, 32'h0, rd_q);
      apb(1'b0, lcl_pkg::HA_RDATA, 32'h0, rd_q);
   endtask : dev
   task automatic rd(input logic [11:0] a, input logic [31:0] e,
      input string nm);
      logic [31:0] r;
      dev(1'b0, a, 32'h0, r);
      chk(nm, r, e);
   endtask : rd
   task automatic wr(input logic [11:0] a, input logic [31:0] wd);
      logic [31:0] r;
      dev(1'b1, a, wd, r);
   endtask : wr
   // each burst compared against the oldest note of the driver
   always @(posedge sys_clk)
   begin
      if (load_clk_en === 1'b1)
      begin
         if (run == 0)
            chk("load_data", load_data, exp_d.pop_front());
         run = run + 1;
      end
      else if (run != 0)
      begin
         chk("burst_len", run, exp_n.pop_front());
         run = 0;
      end
   end
   // watchdog: a hang counts as a mismatch
   initial
   begin
      #2000000;
      err_total++;
      end_of_test();
   end
   initial
   begin
      repeat (20) @(posedge sys_clk);
      srst <= 1'b0;
      rd(lcl_pkg::OFS_MODE, 32'h0, "mode_rst");
      rd(lcl_pkg::OFS_DATA, 32'h0, "data_rst");
      repeat (4)
      begin
         st <= 8'($random(seed));
         repeat (4) @(posedge sys_clk);
         dev(1'b0, lcl_pkg::OFS_ID_STATUS, 32'h0, q);
         chk("board_id", 32'(q[15:0]), 32'(BID));
         chk("st_9_8", 32'(q[25:24]), 32'(st[7:6]));
         chk("st_7_6", 32'(q[23:22]), 32'(st[5:4]));
         chk("st_5_4", 32'(q[21:20]), 32'(st[3:2]));
         chk("st_3_2", 32'(q[19:18]), 32'(st[1:0]));
         chk("st_rsv", {24'h0, q[31:26], q[17:16]}, 32'h0);
      end
      st <= 8'h88;
      // clock source moves only after a quiet spell, then rests again
      repeat (IDLE_CYC) @(posedge sys_clk);
      wr(lcl_pkg::OFS_MODE, 32'hffff_ffff);
      repeat (IDLE_CYC) @(posedge sys_clk);
      rd(lcl_pkg::OFS_MODE, 32'h0000_ff06, "refused");
      chk("mode_out", {29'h0, full_reload_request, core_clock_source,
         link_load_mode}, 32'h6);
      // fabric user mode off must gate the clock source
      st <= 8'h80;
      repeat (5) @(posedge sys_clk);
      chk("clk_gate", {31'h0, core_clock_source}, 32'h0);
      st <= 8'h88;
      apb(1'b1, lcl_pkg::HA_MEMWR, 32'h1, q);
      wr(lcl_pkg::OFS_MODE, 32'h0);
      apb(1'b1, lcl_pkg::HA_MEMWR, 32'h0, q);
      rd(lcl_pkg::OFS_MODE, 32'h0000_ff06, "memwr_off");
      st <= 8'h8c;
      foreach (cnt[i])
      begin
         n = (cnt[i][5:0] == 6'h00) ? 32'h40 : {26'h0, cnt[i][5:0]};
         wr(lcl_pkg::OFS_MODE, {16'h0, cnt[i], 8'h03});
         for (int j = 0; j < 2; j++)
         begin
            d = $random(seed);
            exp_d.push_back(d);
            exp_n.push_back(n);
            apb(1'b1, lcl_pkg::HA_MEMWR, {31'h0, j[0]}, q);
            wr(j[0] ? 12'h010 : lcl_pkg::OFS_DATA, d);
         end
         apb(1'b1, lcl_pkg::HA_MEMWR, 32'h0, q);
      end
      rd(lcl_pkg::OFS_MODE, 32'h0000_c503, "count_store");
      chk("load_mode", {31'h0, link_load_mode}, 32'h1);
      st <= 8'h8e;
      rd(lcl_pkg::OFS_UE_STATUS, 32'h20, "err_set");
      wr(lcl_pkg::OFS_UE_STATUS, 32'h20);
      rd(lcl_pkg::OFS_UE_STATUS, 32'h0, "err_clr");
      wr(lcl_pkg::OFS_PROG, 32'hffff_ffff);
      rd(lcl_pkg::OFS_PROG, 32'h3, "prog");
      chk("prog_out", {30'h0, transfer_start, load_request},
         32'h3);
      repeat (80) @(posedge sys_clk);
      chk("notes_left", exp_n.size(), 32'h0);
      end_of_test();
   end
endmodule : lcl_bench
`default_nettype wire
